// ### core/bit_vote.sv
`timescale 1ns/100ps
// two-of-three vote over the middle samples of a bit
module bit_vote (
	// samples 8, 9 and 10 of one bit
	input wire logic [2:0] samples,
	// voted value and disagreement
	output logic bit_val,
	output logic noisy
);
	// majority gives the bit, any disagreement is noise
	assign bit_val = (samples[0] & samples[1]) | (samples[1] & samples[2])
		| (samples[0] & samples[2]); // see RULE21
	assign noisy = (samples != 3'h0) && (samples != 3'h7); // see RULE21
endmodule : bit_vote

// ### core/parity_check.sv
`timescale 1ns/100ps
// parity check over a received word, top bit only counted in long words
module parity_check #(
	parameter int WIDTH = 9
) (
	// received word, parity bit at the top in long words and one bit lower in short ones
	input wire logic [WIDTH-1:0] word,
	input wire logic word_long,
	input wire logic odd_sel,
	// mismatch
	output logic err
);
	logic [WIDTH-1:0] masked;
	// short words carry parity one bit lower, so the top bit is dropped
	assign masked = word_long ? word : {1'b0, word[WIDTH-2:0]};
	// even count expected with odd_sel low, odd count with it high
	assign err = (^masked) != odd_sel; // see RULE22
endmodule : parity_check

// ### core/uart_flags_pkg.sv
package uart_flags_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_CTRL1 = 8'h08;
	localparam logic [7:0] OFF_CTRL2 = 8'h0c;
	// line_status bit positions
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_TX_DONE = 6;
	localparam int BIT_RX_READY = 5;
	localparam int BIT_IDLE = 4;
	localparam int BIT_OVERRUN = 3;
	localparam int BIT_NOISE = 2;
	localparam int BIT_FRAME_ERR = 1;
	localparam int BIT_PARITY_ERR = 0;
	// ctrl_reg_one bit positions
	localparam int C1_WORD_LEN = 4;
	localparam int C1_PAR_EN = 2;
	localparam int C1_PAR_SEL = 1;
	localparam int C1_PAR_IE = 0;
	// ctrl_reg_two bit positions
	localparam int C2_TX_EMPTY_IE = 7;
	localparam int C2_TX_DONE_IE = 6;
	localparam int C2_RX_IE = 5;
	localparam int C2_IDLE_IE = 4;
	// reset values
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic TX_EMPTY_RST = 1'b1;
	localparam logic TX_DONE_RST = 1'b1;
	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// kind of frame the transmitter just finished
	typedef enum logic [2:0] {
		KIND_DATA = 3'b001,
		KIND_IDLE = 3'b010,
		KIND_BREAK = 3'b100
	} frame_kind_t;
	// progress of the software clearing sequence
	typedef enum logic [2:0] {
		SEQ_NONE = 3'b001,
		SEQ_ACC = 3'b010,
		SEQ_RD = 3'b100
	} seq_state_t;
endpackage : uart_flags_pkg

// ### core/uart_status_flags.sv
// How it works
// RULE1: set tx empty flag when holding data moves into the shifter.
// RULE2: interrupt while tx empty flag and its enable are both set.
// RULE3: tx flags clear only by status access then data write.
// RULE4: set tx done flag when a data frame finishes sending.
// RULE5: idle preamble or break frames leave tx done flag unchanged.
// RULE6: interrupt while tx done flag and its enable are both set.
// RULE7: set rx ready flag when a word moves into the readable buffer.
// RULE8: interrupt on rx ready or overrun when receive enable is set.
// RULE9: rx, idle, overrun, noise, frame flags clear by status access then data read.
// RULE10: set idle flag on idle line; interrupt when idle enable set.
// RULE11: after idle clears it stays clear until a new word arrives.
// RULE12: set overrun when a word completes while rx ready is still set.
// RULE13: on overrun keep the buffer; the shifter may be overwritten.
// RULE14: set noise flag when noise is seen during a frame.
// RULE15: noise and frame error raise no interrupt of their own.
// RULE16: set frame error on desync, excessive noise or break; the code sets it on desync or break only.
// RULE17: frame error together with overrun sets only overrun.
// RULE18: set parity error flag when a word fails its parity check.
// RULE19: interrupt while parity error flag and its enable are set.
// RULE20: parity error clears by status read then data access.
// RULE21: samples 8, 9, 10 disagreeing mean noise; majority is the bit.
// RULE22: even parity when select is 0, odd when 1; flag a mismatch.
// RULE23: all events share one interrupt request line.
// RULE24: bus writes to the status register are ignored.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module uart_status_flags #(
	parameter int WORD_W = 9
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// transmitter side
	input wire logic tx_load,
	input wire logic tx_frame_end,
	input wire uart_flags_pkg::frame_kind_t tx_frame_kind,
	output logic [WORD_W-1:0] tx_data,
	output logic tx_data_full,
	// receiver side
	input wire logic rx_bit_strobe,
	input wire logic [2:0] rx_samples,
	input wire logic rx_start_noise,
	input wire logic rx_word_valid,
	input wire logic [WORD_W-1:0] rx_word,
	input wire logic rx_desync,
	input wire logic rx_break,
	input wire logic idle_detect,
	output logic rx_bit_value,
	output logic rx_bit_valid,
	// line configuration
	output logic word_long,
	output logic parity_enable,
	output logic parity_select,
	// shared interrupt request
	output logic irq
);
	// data phase bookkeeping
	logic dp_valid_q;
	logic dp_write_q;
	logic [7:0] dp_addr_q;
	// software registers
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [WORD_W-1:0] tx_hold_q;
	logic tx_full_q;
	logic [WORD_W-1:0] rx_buf_q;
	// status flags
	logic tx_empty_q;
	logic tx_done_q;
	logic rx_ready_q;
	logic idle_q;
	logic overrun_q;
	logic noise_q;
	logic frame_err_q;
	logic parity_err_q;
	logic [7:0] line_status;
	// receive helpers
	logic idle_block_q;
	logic noise_acc_q;
	logic vote_val;
	logic vote_noisy;
	logic par_err_w;
	logic rx_bit_q;
	logic rx_bit_valid_q;
	logic irq_q;
	// clearing sequence
	uart_flags_pkg::seq_state_t seq_q;
	uart_flags_pkg::seq_state_t seq_d;
	// decoded accesses in the data phase
	logic acc_status;
	logic rd_status;
	logic wr_data;
	logic rd_data;
	logic wr_ctrl1;
	logic wr_ctrl2;
	logic clr_tx;
	logic clr_rx;
	logic clr_par;
	// receive event terms
	logic load_ok;
	logic overrun_hit;
	logic idle_set;
	logic noise_now;

	// capture each address phase that this slave takes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end else if (hready) begin
			dp_valid_q <= hsel && (htrans == uart_flags_pkg::HTRANS_NONSEQ);
			dp_write_q <= hwrite;
			dp_addr_q <= haddr;
		end
	end

	// never stalls, never errors; size is not checked, every access is a word
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// decode of the data phase
	assign acc_status = dp_valid_q && (dp_addr_q == uart_flags_pkg::OFF_STATUS);
	assign rd_status = acc_status && !dp_write_q;
	assign wr_data = dp_valid_q && dp_write_q && (dp_addr_q == uart_flags_pkg::OFF_DATA);
	assign rd_data = dp_valid_q && !dp_write_q && (dp_addr_q == uart_flags_pkg::OFF_DATA);
	assign wr_ctrl1 = dp_valid_q && dp_write_q && (dp_addr_q == uart_flags_pkg::OFF_CTRL1);
	assign wr_ctrl2 = dp_valid_q && dp_write_q && (dp_addr_q == uart_flags_pkg::OFF_CTRL2);

	// status image
	always_comb begin
		line_status = 8'h00;
		line_status[uart_flags_pkg::BIT_TX_EMPTY] = tx_empty_q;
		line_status[uart_flags_pkg::BIT_TX_DONE] = tx_done_q;
		line_status[uart_flags_pkg::BIT_RX_READY] = rx_ready_q;
		line_status[uart_flags_pkg::BIT_IDLE] = idle_q;
		line_status[uart_flags_pkg::BIT_OVERRUN] = overrun_q;
		line_status[uart_flags_pkg::BIT_NOISE] = noise_q;
		line_status[uart_flags_pkg::BIT_FRAME_ERR] = frame_err_q;
		line_status[uart_flags_pkg::BIT_PARITY_ERR] = parity_err_q;
	end

	// read mux straight from the register flops; unmapped reads give zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (dp_valid_q && !dp_write_q) begin
			case (dp_addr_q)
				uart_flags_pkg::OFF_STATUS: hrdata[7:0] = line_status;
				uart_flags_pkg::OFF_DATA: hrdata[WORD_W-1:0] = rx_buf_q;
				uart_flags_pkg::OFF_CTRL1: hrdata[7:0] = ctrl1_q;
				uart_flags_pkg::OFF_CTRL2: hrdata[7:0] = ctrl2_q;
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// clearing sequence: remember a status access until the next data access
	always_comb begin
		seq_d = seq_q;
		case (seq_q)
			uart_flags_pkg::SEQ_NONE,
			uart_flags_pkg::SEQ_ACC,
			uart_flags_pkg::SEQ_RD: begin
				if (wr_data || rd_data) begin
					seq_d = uart_flags_pkg::SEQ_NONE;
				end else if (rd_status) begin
					seq_d = uart_flags_pkg::SEQ_RD;
				end else if (acc_status) begin
					seq_d = uart_flags_pkg::SEQ_ACC;
				end
			end
			default: seq_d = uart_flags_pkg::SEQ_NONE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_q <= uart_flags_pkg::SEQ_NONE;
		end else begin
			seq_q <= seq_d;
		end
	end

	// the data access that completes a sequence
	assign clr_tx = wr_data && (seq_q != uart_flags_pkg::SEQ_NONE); // see RULE3
	assign clr_rx = rd_data && (seq_q != uart_flags_pkg::SEQ_NONE); // see RULE9
	assign clr_par = (wr_data || rd_data) && (seq_q == uart_flags_pkg::SEQ_RD); // see RULE20

	// control registers; status has no write path at all
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl1_q <= uart_flags_pkg::CTRL1_RST;
			ctrl2_q <= uart_flags_pkg::CTRL2_RST;
		end else begin
			if (wr_ctrl1) begin
				ctrl1_q <= hwdata[7:0];
			end
			if (wr_ctrl2) begin
				ctrl2_q <= hwdata[7:0];
			end
		end
	end // see RULE24

	assign word_long = ctrl1_q[uart_flags_pkg::C1_WORD_LEN];
	assign parity_enable = ctrl1_q[uart_flags_pkg::C1_PAR_EN];
	assign parity_select = ctrl1_q[uart_flags_pkg::C1_PAR_SEL];

	// transmit holding register; full until the shifter takes it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_hold_q <= '0;
			tx_full_q <= 1'b0;
		end else begin
			if (wr_data) begin
				tx_hold_q <= hwdata[WORD_W-1:0];
			end
			if (wr_data) begin
				tx_full_q <= 1'b1;
			end else if (tx_load) begin
				tx_full_q <= 1'b0;
			end
		end
	end

	assign tx_data = tx_hold_q;
	assign tx_data_full = tx_full_q;

	// tx empty: a load sets it, and the set beats a same-cycle clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_empty_q <= uart_flags_pkg::TX_EMPTY_RST;
		end else if (tx_load) begin
			tx_empty_q <= 1'b1; // see RULE1
		end else if (clr_tx) begin
			tx_empty_q <= 1'b0; // see RULE3
		end
	end

	// tx done: only frames that carry data count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_done_q <= uart_flags_pkg::TX_DONE_RST;
		end else if (tx_frame_end && (tx_frame_kind == uart_flags_pkg::KIND_DATA)) begin
			tx_done_q <= 1'b1; // see RULE4
		end else if (clr_tx) begin
			tx_done_q <= 1'b0; // see RULE3
		end
	end // preamble and break ends fall through untouched, see RULE5

	// middle-sample vote of the bit being received
	bit_vote u_vote (
		.samples(rx_samples),
		.bit_val(vote_val),
		.noisy(vote_noisy)
	);

	// voted bit handed back to the receiver's shifter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_bit_q <= 1'b1;
			rx_bit_valid_q <= 1'b0;
		end else begin
			rx_bit_valid_q <= rx_bit_strobe;
			if (rx_bit_strobe) begin
				rx_bit_q <= vote_val; // see RULE21
			end
		end
	end

	assign rx_bit_value = rx_bit_q;
	assign rx_bit_valid = rx_bit_valid_q;

	// noise seen anywhere in the frame, held until the word completes
	assign noise_now = rx_start_noise || (rx_bit_strobe && vote_noisy);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			noise_acc_q <= 1'b0;
		end else if (rx_word_valid) begin
			noise_acc_q <= 1'b0;
		end else if (noise_now) begin
			noise_acc_q <= 1'b1; // see RULE14
		end
	end

	// parity of the incoming word against the selected sense
	parity_check #(
		.WIDTH(WORD_W)
	) u_parity (
		.word(rx_word),
		.word_long(word_long),
		.odd_sel(parity_select),
		.err(par_err_w)
	);

	// a word either loads the buffer or, with data still unread, overruns
	assign load_ok = rx_word_valid && !rx_ready_q;
	assign overrun_hit = rx_word_valid && rx_ready_q; // see RULE12

	// buffer keeps its old word on overrun; the shifter is not held off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_buf_q <= '0;
		end else if (load_ok) begin
			rx_buf_q <= rx_word; // see RULE13
		end
	end

	// rx ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_ready_q <= 1'b0;
		end else if (load_ok) begin
			rx_ready_q <= 1'b1; // see RULE7
		end else if (clr_rx) begin
			rx_ready_q <= 1'b0; // see RULE9
		end
	end

	// overrun
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_q <= 1'b0;
		end else if (overrun_hit) begin
			overrun_q <= 1'b1; // see RULE12
		end else if (clr_rx) begin
			overrun_q <= 1'b0; // see RULE9
		end
	end

	// frame error only on a word that was actually transferred
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_err_q <= 1'b0;
		end else if (load_ok && (rx_desync || rx_break)) begin
			frame_err_q <= 1'b1; // see RULE16
		end else if (clr_rx) begin
			frame_err_q <= 1'b0; // see RULE9
		end
	end // an overrun word never reaches the set term, see RULE17

	// noise flag lands together with rx ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			noise_q <= 1'b0;
		end else if (load_ok && (noise_acc_q || noise_now)) begin
			noise_q <= 1'b1; // see RULE14
		end else if (clr_rx) begin
			noise_q <= 1'b0; // see RULE9
		end
	end

	// parity error, checked only with parity enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			parity_err_q <= 1'b0;
		end else if (load_ok && parity_enable && par_err_w) begin
			parity_err_q <= 1'b1; // see RULE18
		end else if (clr_par) begin
			parity_err_q <= 1'b0; // see RULE20
		end
	end

	// idle may set once per received word; a clear arms the block
	assign idle_set = idle_detect && !idle_block_q; // see RULE11

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_q <= 1'b0;
		end else if (idle_set) begin
			idle_q <= 1'b1; // see RULE10
		end else if (clr_rx) begin
			idle_q <= 1'b0; // see RULE9
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_block_q <= 1'b0;
		end else if (load_ok) begin
			idle_block_q <= 1'b0; // see RULE11
		end else if (clr_rx && idle_q && !idle_set) begin
			idle_block_q <= 1'b1; // see RULE11
		end
	end

	// one shared request; noise and frame error have no enable of their own
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (tx_empty_q && ctrl2_q[uart_flags_pkg::C2_TX_EMPTY_IE]) // see RULE2
				|| (tx_done_q && ctrl2_q[uart_flags_pkg::C2_TX_DONE_IE]) // see RULE6
				|| ((rx_ready_q || overrun_q) && ctrl2_q[uart_flags_pkg::C2_RX_IE]) // see RULE8
				|| (idle_q && ctrl2_q[uart_flags_pkg::C2_IDLE_IE]) // see RULE10
				|| (parity_err_q && ctrl1_q[uart_flags_pkg::C1_PAR_IE]); // see RULE19
		end
	end // see RULE23 and RULE15

	assign irq = irq_q;
endmodule : uart_status_flags

// ### tb/far_end.sv
`timescale 1ns/100ps
// shifter-side events as the line engines would raise them
module far_end (
	// clock
	input wire logic clk,
	// transmitter events
	output logic tx_load,
	output logic tx_frame_end,
	output uart_flags_pkg::frame_kind_t tx_frame_kind,
	// receiver events
	output logic rx_bit_strobe,
	output logic [2:0] rx_samples,
	output logic rx_start_noise,
	output logic rx_word_valid,
	output logic [8:0] rx_word,
	output logic rx_desync,
	output logic rx_break,
	output logic idle_detect
);
	initial begin
		{tx_load, tx_frame_end, rx_bit_strobe, rx_start_noise, rx_word_valid} = 5'h00;
		{rx_desync, rx_break, idle_detect, rx_samples, rx_word} = 15'h0000;
		tx_frame_kind = uart_flags_pkg::KIND_DATA;
	end
	// one-cycle transmitter pulse: load, or frame end of a kind
	task automatic tx_ev(input logic ld, input uart_flags_pkg::frame_kind_t k);
		@(posedge clk);
		tx_load <= ld;
		tx_frame_end <= !ld;
		tx_frame_kind <= k;
		@(posedge clk);
		{tx_load, tx_frame_end} <= 2'b00;
	endtask : tx_ev
	// words are handed over whether or not the last was read
	task automatic rx_ev(input logic [8:0] w, input logic ds, input logic bk, input logic nz);
		@(posedge clk);
		{rx_word_valid, rx_word, rx_desync, rx_break, rx_start_noise} <= {1'b1, w, ds, bk, nz};
		@(posedge clk);
		{rx_word_valid, rx_desync, rx_break, rx_start_noise} <= 4'h0;
		rx_word <= ~w; // stale word must not look valid
	endtask : rx_ev
	task automatic bit_ev(input logic [2:0] s);
		@(posedge clk);
		{rx_bit_strobe, rx_samples} <= {1'b1, s};
		@(posedge clk);
		{rx_bit_strobe, rx_samples} <= {1'b0, ~s};
	endtask : bit_ev
	task automatic line_idle;
		@(posedge clk);
		idle_detect <= 1'b1;
		@(posedge clk);
		idle_detect <= 1'b0;
	endtask : line_idle
endmodule : far_end

// ### tb/flags_checker_assertions.sv
`timescale 1ns/100ps
// bus, transmit holding, receiver and line configuration relations seen at the block's pins
module flags_checker #(
	parameter int WORD_W = 9
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// line side
	input wire logic tx_load,
	input wire logic [WORD_W-1:0] tx_data,
	input wire logic tx_data_full,
	input wire logic rx_bit_strobe,
	input wire logic [2:0] rx_samples,
	input wire logic rx_bit_value,
	input wire logic rx_bit_valid,
	input wire logic word_long,
	input wire logic parity_enable,
	input wire logic parity_select
);
	logic dv_q;
	logic dw_q;
	logic [7:0] da_q;
	logic maj;
	logic wr_data;
	logic wr_cfg;
	// remember the address phase so its data phase can be judged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dv_q <= 1'b0;
			dw_q <= 1'b0;
			da_q <= 8'h00;
		end else if (hready) begin
			dv_q <= hsel && htrans == uart_flags_pkg::HTRANS_NONSEQ;
			dw_q <= hwrite;
			da_q <= haddr;
		end
	end
	// vote written apart from the design's own voter
	assign maj = (rx_samples[0] & rx_samples[1]) | (rx_samples[2] & (rx_samples[0] | rx_samples[1]));
	assign wr_data = dv_q && dw_q && da_q == uart_flags_pkg::OFF_DATA;
	assign wr_cfg = dv_q && dw_q && da_q == uart_flags_pkg::OFF_CTRL1;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not okay");
	property p_upper;
		dv_q && !dw_q && da_q == uart_flags_pkg::OFF_STATUS |-> hrdata[31:8] == 24'h000000;
	endproperty
	a_upper: assert property (p_upper) else $error("status upper bits set");
	property p_vote; rx_bit_strobe |=> rx_bit_valid && rx_bit_value == $past(maj); endproperty
	a_vote: assert property (p_vote) else $error("voted bit wrong");
	property p_valid; !rx_bit_strobe |=> !rx_bit_valid; endproperty
	a_valid: assert property (p_valid) else $error("bit valid without strobe");
	property p_load; tx_load && !wr_data |=> !tx_data_full; endproperty
	a_load: assert property (p_load) else $error("holding still full after load");
	property p_hold;
		wr_data && !tx_load |=> tx_data_full && tx_data == $past(hwdata[WORD_W-1:0]);
	endproperty
	a_hold: assert property (p_hold) else $error("holding write lost");
	property p_cfg;
		wr_cfg |=> {word_long, parity_enable, parity_select} == $past({hwdata[4], hwdata[2:1]});
	endproperty
	a_cfg: assert property (p_cfg) else $error("line config not stored");
	property p_cfg_keep; !wr_cfg |=> $stable(parity_select) && $stable(word_long); endproperty
	a_cfg_keep: assert property (p_cfg_keep) else $error("line config moved");
	c_bit: cover property (rx_bit_strobe && rx_samples == 3'b011);
	c_load: cover property (tx_load);
	c_cfg: cover property (wr_cfg);
endmodule : flags_checker

bind uart_status_flags flags_checker #(.WORD_W(WORD_W)) u_flags_checker (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.tx_load(tx_load), .tx_data(tx_data), .tx_data_full(tx_data_full),
	.rx_bit_strobe(rx_bit_strobe), .rx_samples(rx_samples), .rx_bit_value(rx_bit_value),
	.rx_bit_valid(rx_bit_valid), .word_long(word_long), .parity_enable(parity_enable),
	.parity_select(parity_select));

// ### tb/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, d;
	logic tx_load, tx_frame_end, rx_bit_strobe, rx_start_noise, rx_word_valid, rx_desync;
	logic rx_break, idle_detect, tx_data_full, rx_bit_value, rx_bit_valid;
	logic word_long, parity_enable, parity_select;
	logic [2:0] rx_samples;
	logic [8:0] rx_word, tx_data;
	uart_flags_pkg::frame_kind_t tx_frame_kind;
	int err_total, n_checks;
	uart_status_flags u_uart_status_flags (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tx_load(tx_load), .tx_frame_end(tx_frame_end), .tx_frame_kind(tx_frame_kind),
		.tx_data(tx_data), .tx_data_full(tx_data_full), .rx_bit_strobe(rx_bit_strobe),
		.rx_samples(rx_samples), .rx_start_noise(rx_start_noise), .rx_word_valid(rx_word_valid),
		.rx_word(rx_word), .rx_desync(rx_desync), .rx_break(rx_break), .idle_detect(idle_detect),
		.rx_bit_value(rx_bit_value), .rx_bit_valid(rx_bit_valid), .word_long(word_long),
		.parity_enable(parity_enable), .parity_select(parity_select), .irq(irq));
	far_end u_far_end (.clk(hclk), .tx_load(tx_load), .tx_frame_end(tx_frame_end),
		.tx_frame_kind(tx_frame_kind), .rx_bit_strobe(rx_bit_strobe), .rx_samples(rx_samples),
		.rx_start_noise(rx_start_noise), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
		.rx_desync(rx_desync), .rx_break(rx_break), .idle_detect(idle_detect));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	task automatic summarize;
		if (err_total == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	// bounded wait for hready at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			summarize();
		end
	endtask : wait_ready
	// one single-word transfer; read data lands in d
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		{hsel, haddr, htrans, hwrite} <= {1'b1, a, uart_flags_pkg::HTRANS_NONSEQ, w};
		wait_ready();
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
		wait_ready();
		d = hrdata;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(d, e)
	endtask : rd
	// irq is registered, so let the flag and then irq settle
	task automatic irq_is(input logic e);
		repeat (2) @(posedge hclk);
		#1;
		`CHK(irq, e)
	endtask : irq_is
	initial begin
		{err_total, n_checks, hresetn, hsel, haddr, htrans, hwrite, hwdata} = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rd(8'h00, 32'hc0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h10, 32'h0);
		bus(1'b1, 8'h00, 32'h0);
		rd(8'h00, 32'hc0);
		bus(1'b1, 8'h0c, 32'hc0);
		irq_is(1'b1);
		bus(1'b1, 8'h04, 32'h1a5);
		rd(8'h00, 32'h00);
		`CHK(tx_data, 9'h1a5)
		irq_is(1'b0);
		u_far_end.tx_ev(1'b1, uart_flags_pkg::KIND_DATA);
		rd(8'h00, 32'h80);
		irq_is(1'b1);
		u_far_end.tx_ev(1'b0, uart_flags_pkg::KIND_IDLE);
		u_far_end.tx_ev(1'b0, uart_flags_pkg::KIND_BREAK);
		rd(8'h00, 32'h80);
		u_far_end.tx_ev(1'b0, uart_flags_pkg::KIND_DATA);
		rd(8'h00, 32'hc0);
		bus(1'b1, 8'h0c, 32'h20);
		irq_is(1'b0);
		u_far_end.rx_ev(9'h055, 1'b0, 1'b0, 1'b0);
		rd(8'h00, 32'he0);
		irq_is(1'b1);
		rd(8'h04, 32'h55);
		rd(8'h00, 32'hc0);
		u_far_end.rx_ev(9'h011, 1'b0, 1'b0, 1'b0);
		u_far_end.rx_ev(9'h022, 1'b1, 1'b0, 1'b0);
		rd(8'h00, 32'he8);
		rd(8'h04, 32'h11);
		rd(8'h00, 32'hc0);
		bus(1'b1, 8'h0c, 32'h0);
		u_far_end.rx_ev(9'h033, 1'b0, 1'b1, 1'b1);
		rd(8'h00, 32'he6);
		irq_is(1'b0);
		rd(8'h04, 32'h33);
		rd(8'h00, 32'hc0);
		u_far_end.rx_ev(9'h044, 1'b1, 1'b0, 1'b0);
		rd(8'h00, 32'he2);
		rd(8'h04, 32'h44);
		bus(1'b1, 8'h08, 32'h04);
		u_far_end.rx_ev(9'h001, 1'b0, 1'b0, 1'b0);
		rd(8'h00, 32'he1);
		bus(1'b1, 8'h04, 32'h0);
		rd(8'h00, 32'h20);
		rd(8'h04, 32'h01);
		bus(1'b1, 8'h08, 32'h07);
		u_far_end.rx_ev(9'h001, 1'b0, 1'b0, 1'b0);
		rd(8'h00, 32'h20);
		irq_is(1'b0);
		rd(8'h04, 32'h01);
		u_far_end.rx_ev(9'h003, 1'b0, 1'b0, 1'b0);
		rd(8'h00, 32'h21);
		irq_is(1'b1);
		rd(8'h04, 32'h03);
		rd(8'h00, 32'h00);
		bus(1'b1, 8'h08, 32'h14);
		u_far_end.rx_ev(9'h100, 1'b0, 1'b0, 1'b0);
		rd(8'h00, 32'h21);
		rd(8'h04, 32'h100);
		bus(1'b1, 8'h08, 32'h0);
		bus(1'b1, 8'h0c, 32'h10);
		u_far_end.line_idle();
		rd(8'h00, 32'h10);
		irq_is(1'b1);
		bus(1'b0, 8'h04, 32'h0);
		u_far_end.line_idle();
		rd(8'h00, 32'h00);
		u_far_end.rx_ev(9'h000, 1'b0, 1'b0, 1'b0);
		u_far_end.line_idle();
		rd(8'h00, 32'h30);
		bus(1'b0, 8'h04, 32'h0);
		// tx done alone, with tx empty still clear, must raise the request
		bus(1'b1, 8'h0c, 32'h40);
		irq_is(1'b0);
		u_far_end.tx_ev(1'b0, uart_flags_pkg::KIND_DATA);
		irq_is(1'b1);
		// every sample pattern; majority is one for 3, 5, 6 and 7
		for (int i = 0; i < 8; i++) begin
			u_far_end.bit_ev(3'(i));
			#1;
			`CHK({rx_bit_valid, rx_bit_value}, {1'b1, i == 3 || i > 4})
		end
		u_far_end.rx_ev(9'h000, 1'b0, 1'b0, 1'b0);
		rd(8'h00, 32'h64);
		summarize();
	end
endmodule : testbench
